// ===== src/fsl_pkg.sv
// Constants, command codes and carrier types for the fault limit bank
package fsl_pkg;

   // Clock rate and derived hiccup step
   localparam int unsigned CLOCK_MHZ        = 200;
   localparam int unsigned RESTART_STEP_US  = 1000;
   localparam int unsigned RESTART_STEP_CYC = RESTART_STEP_US * CLOCK_MHZ;

   // Command codes of the bank
   localparam logic [7:0] CMD_OC_WARN_LIM  = 8'h4A;
   localparam logic [7:0] CMD_OT_FAULT_LIM = 8'h4F;
   localparam logic [7:0] CMD_OT_ACTION    = 8'h50;
   localparam logic [7:0] CMD_OT_WARN_LIM  = 8'h51;
   localparam logic [7:0] CMD_VIN_OV_LIM   = 8'h55;

   // Reset values as held by the nonvolatile store
   localparam logic [15:0] RST_OC_WARN_LIM  = 16'hF81F;
   localparam logic [15:0] RST_OT_FAULT_LIM = 16'h007D;
   localparam logic [7:0]  RST_OT_ACTION    = 8'hF9;
   localparam logic [15:0] RST_OT_WARN_LIM  = 16'h0069;
   localparam logic [15:0] RST_VIN_OV_LIM   = 16'hF81E;

   // Two-byte number layout: exponent high, mantissa low
   localparam int unsigned MANT_LSB = 0;
   localparam int unsigned MANT_W   = 11;
   localparam int unsigned EXP_LSB  = 11;
   localparam int unsigned EXP_W    = 5;

   // Fixed exponents and mantissa ranges per threshold
   localparam logic [4:0]  EXP_HALF  = 5'h1F;
   localparam logic [4:0]  EXP_UNIT  = 5'h00;
   localparam logic [10:0] OC_MIN    = 11'h000;
   localparam logic [10:0] OC_MAX    = 11'h0FE;
   localparam logic [10:0] OT_MIN    = 11'h000;
   localparam logic [10:0] OT_MAX    = 11'h096;
   localparam logic [10:0] VIN_MIN   = 11'h002;
   localparam logic [10:0] VIN_MAX   = 11'h0A0;

   // Fault action field positions
   localparam int unsigned ACT_SEL_LSB = 6;
   localparam int unsigned ACT_RTY_LSB = 3;
   localparam int unsigned ACT_DLY_LSB = 0;
   localparam logic [2:0]  RTY_FOREVER = 3'h7;

   // Host command request from the management bus engine
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  code;
      logic [15:0] data;
   } fsl_req_t;

   // Live measurements, in the units of their thresholds
   typedef struct packed {
      logic [10:0] temperature;
      logic [10:0] inputVolt;
      logic [10:0] outputCurr;
   } fsl_meas_t;

   // Alarm levels raised by the bank
   typedef struct packed {
      logic otFault;
      logic otWarn;
      logic vinOvFault;
      logic ocWarn;
   } fsl_alarm_t;

endpackage : fsl_pkg

// ===== src/fsl_limit_check.sv
// Range and resolution check of one two-byte threshold write
`timescale 1ns/10ps
module fsl_limit_check #(
   parameter logic [4:0]  FIX_EXP = 5'h00,
   parameter logic [10:0] MIN_MAN = 11'h000,
   parameter logic [10:0] MAX_MAN = 11'h000
) (
   input  wire logic [15:0] value,
   output logic             valid
);

   logic [4:0]  expField;
   logic [10:0] manField;

   // Split the word into its two signed fields
   assign expField = value[fsl_pkg::EXP_LSB +: fsl_pkg::EXP_W];
   assign manField = value[fsl_pkg::MANT_LSB +: fsl_pkg::MANT_W];

   // Wrong exponent means wrong resolution; negative mantissa is below range
   always_comb begin
      valid = (expField == FIX_EXP)
            && !manField[10]
            && (manField >= MIN_MAN)
            && (manField <= MAX_MAN);
   end

endmodule : fsl_limit_check

// ===== src/fsl_ot_response.sv
// Output enable sequencing in answer to an overtemperature fault
`timescale 1ns/10ps
module fsl_ot_response #(
   parameter int unsigned STEP_CYC = fsl_pkg::RESTART_STEP_CYC
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [7:0] action,
   input  wire logic       fault,
   input  wire logic       runCmd,
   input  wire logic       clearFault,
   output logic            allowRun
);

   typedef enum logic [1:0] {RUNNING, HELD, WAITING, LATCHED} fsl_ots_t;

   fsl_ots_t    state_r;
   logic [1:0]  sel;
   logic [2:0]  rty;
   logic [2:0]  dly;
   logic [31:0] wait_r;
   logic [31:0] waitLen;

   assign sel     = action[fsl_pkg::ACT_SEL_LSB +: 2];
   assign rty     = action[fsl_pkg::ACT_RTY_LSB +: 3];
   assign dly     = action[fsl_pkg::ACT_DLY_LSB +: 3];
   assign waitLen = STEP_CYC * {29'h0, dly};

   // Being commanded off ends any hold or latch; a zero selector never stops
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r <= RUNNING;
         wait_r  <= 32'h0;
      end else if (!runCmd) begin
         state_r <= RUNNING;
         wait_r  <= 32'h0;
      end else begin
         case (state_r)
            RUNNING: begin
               if (fault && sel != 2'b00) begin
                  if (rty == 3'h0 && dly == 3'h0)
                     state_r <= LATCHED;
                  else
                     state_r <= HELD;
               end
            end
            HELD: begin
               wait_r <= 32'h0;
               if (!fault) begin
                  // Unlimited retry waits the restart delay before resuming
                  if (rty == fsl_pkg::RTY_FOREVER && dly != 3'h0)
                     state_r <= WAITING;
                  else
                     state_r <= RUNNING;
               end
            end
            WAITING: begin
               if (fault) begin
                  state_r <= HELD;
               end else if (wait_r + 32'h1 >= waitLen) begin
                  state_r <= RUNNING;
               end else begin
                  wait_r <= wait_r + 32'h1;
               end
            end
            LATCHED: begin
               if (clearFault && !fault)
                  state_r <= RUNNING;
            end
            default: state_r <= RUNNING;
         endcase
      end
   end

   assign allowRun = (state_r == RUNNING) && runCmd;

endmodule : fsl_ot_response

// ===== src/fsl_limit_bank.sv
// Fault and warning threshold registers with alarm comparison
`timescale 1ns/10ps
// What this block does
// - Overcurrent warning accepts 0 to 127 A, half-amp
// - Overcurrent warning resets to 0xF81F, 15.5 A
// - Invalid threshold write dropped, value kept, reported
// - Word is 11-bit mantissa, 5-bit exponent
// - Temperature thresholds use exponent zero, whole degrees
// - Temperature thresholds accept 0 to 150 degrees
// - Fault threshold resets to 125 C; fault raised
// - Warning threshold resets to 0x0069, 105 C
// - Temperature at warning threshold raises warning
// - Input overvoltage threshold exponent minus one
// - Input overvoltage accepts 1 to 80 V, half-volt
// - Input overvoltage resets 15 V; fault raised
// - All registers read back as written; action byte reads back with upper byte zero
// - Fault action byte fields, reset value 0xF9
// - Default action holds off, restarts without limit
// - Selector zero keeps running during fault
// - Selector ones, rest zero, latches off
// - Other ones codes resume when fault clears
// - Overcurrent warning exponent minus one, raised
module fsl_limit_bank #(
   parameter logic [15:0] OC_WARN_DEFAULT = fsl_pkg::RST_OC_WARN_LIM,
   parameter int unsigned STEP_CYC        = fsl_pkg::RESTART_STEP_CYC
) (
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire fsl_pkg::fsl_req_t  req,
   input  wire fsl_pkg::fsl_meas_t meas,
   input  wire logic               reloadStore,
   input  wire logic               clearFaults,
   input  wire logic               runCmd,
   output logic [15:0]             readData_r,
   output logic                    readValid_r,
   output logic                    writeDone_r,
   output logic                    cmdReject_r,
   output logic [7:0]              rejectCode_r,
   output logic                    rejectSticky_r,
   output fsl_pkg::fsl_alarm_t     alarm_r,
   output fsl_pkg::fsl_alarm_t     alarmSticky_r,
   output logic                    outputEnable_r
);

   // Stored thresholds and the fault action byte
   logic [15:0] ocWarnLim_r;
   logic [15:0] otFaultLim_r;
   logic [7:0]  otAction_r;
   logic [15:0] otWarnLim_r;
   logic [15:0] vinOvLim_r;

   // Write validity from the range checkers
   logic        ocOk;
   logic        otFaultOk;
   logic        otWarnOk;
   logic        vinOk;
   logic        writeOk;
   logic        knownCode;
   logic        allowRun;

   // Live compare results and next alarm state
   fsl_pkg::fsl_alarm_t alarm_nxt;

   // True when a measurement reaches a stored threshold
   function automatic logic reaches(input logic [10:0] level,
                                    input logic [15:0] limit);
      logic signed [10:0] lvl;
      logic signed [10:0] lim;
      lvl = level;
      lim = limit[fsl_pkg::MANT_LSB +: fsl_pkg::MANT_W];
      reaches = (lvl >= lim);
   endfunction : reaches

   // True when the code names one of the five registers
   function automatic logic isMapped(input logic [7:0] code);
      isMapped = (code == fsl_pkg::CMD_OC_WARN_LIM)
              || (code == fsl_pkg::CMD_OT_FAULT_LIM)
              || (code == fsl_pkg::CMD_OT_ACTION)
              || (code == fsl_pkg::CMD_OT_WARN_LIM)
              || (code == fsl_pkg::CMD_VIN_OV_LIM);
   endfunction : isMapped

   // Overcurrent warning checker, half-amp units
   fsl_limit_check #(
      .FIX_EXP (fsl_pkg::EXP_HALF),
      .MIN_MAN (fsl_pkg::OC_MIN),
      .MAX_MAN (fsl_pkg::OC_MAX)
   ) u_chk_oc (
      .value   (req.data),
      .valid   (ocOk)
   );

   // Overtemperature fault checker, whole degrees
   fsl_limit_check #(
      .FIX_EXP (fsl_pkg::EXP_UNIT),
      .MIN_MAN (fsl_pkg::OT_MIN),
      .MAX_MAN (fsl_pkg::OT_MAX)
   ) u_chk_otf (
      .value   (req.data),
      .valid   (otFaultOk)
   );

   // Overtemperature warning checker, whole degrees
   fsl_limit_check #(
      .FIX_EXP (fsl_pkg::EXP_UNIT),
      .MIN_MAN (fsl_pkg::OT_MIN),
      .MAX_MAN (fsl_pkg::OT_MAX)
   ) u_chk_otw (
      .value   (req.data),
      .valid   (otWarnOk)
   );

   // Input overvoltage checker, half-volt units
   fsl_limit_check #(
      .FIX_EXP (fsl_pkg::EXP_HALF),
      .MIN_MAN (fsl_pkg::VIN_MIN),
      .MAX_MAN (fsl_pkg::VIN_MAX)
   ) u_chk_vin (
      .value   (req.data),
      .valid   (vinOk)
   );

   // Pick the checker of the addressed register
   always_comb begin
      knownCode = isMapped(req.code);
      case (req.code)
         fsl_pkg::CMD_OC_WARN_LIM:  writeOk = ocOk;
         fsl_pkg::CMD_OT_FAULT_LIM: writeOk = otFaultOk;
         fsl_pkg::CMD_OT_WARN_LIM:  writeOk = otWarnOk;
         fsl_pkg::CMD_VIN_OV_LIM:   writeOk = vinOk;
         // Action byte takes any value; upper data byte ignored
         fsl_pkg::CMD_OT_ACTION:    writeOk = 1'b1;
         default:                   writeOk = 1'b0;
      endcase
   end

   // Threshold storage; a reload restores every stored default at once
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ocWarnLim_r  <= OC_WARN_DEFAULT;
         otFaultLim_r <= fsl_pkg::RST_OT_FAULT_LIM;
         otAction_r   <= fsl_pkg::RST_OT_ACTION;
         otWarnLim_r  <= fsl_pkg::RST_OT_WARN_LIM;
         vinOvLim_r   <= fsl_pkg::RST_VIN_OV_LIM;
      end else if (reloadStore) begin
         ocWarnLim_r  <= OC_WARN_DEFAULT;
         otFaultLim_r <= fsl_pkg::RST_OT_FAULT_LIM;
         otAction_r   <= fsl_pkg::RST_OT_ACTION;
         otWarnLim_r  <= fsl_pkg::RST_OT_WARN_LIM;
         vinOvLim_r   <= fsl_pkg::RST_VIN_OV_LIM;
      end else if (req.wr && writeOk) begin
         // Rejected writes never reach here, so old value stays
         case (req.code)
            fsl_pkg::CMD_OC_WARN_LIM:  ocWarnLim_r  <= req.data;
            fsl_pkg::CMD_OT_FAULT_LIM: otFaultLim_r <= req.data;
            fsl_pkg::CMD_OT_ACTION:    otAction_r   <= req.data[7:0];
            fsl_pkg::CMD_OT_WARN_LIM:  otWarnLim_r  <= req.data;
            fsl_pkg::CMD_VIN_OV_LIM:   vinOvLim_r   <= req.data;
            default: ;
         endcase
      end
   end

   // Read path, one cycle after the strobe; narrow byte padded with zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         readData_r  <= 16'h0000;
         readValid_r <= 1'b0;
      end else begin
         readValid_r <= req.rd && !req.wr && knownCode;
         if (req.rd && !req.wr) begin
            case (req.code)
               fsl_pkg::CMD_OC_WARN_LIM:  readData_r <= ocWarnLim_r;
               fsl_pkg::CMD_OT_FAULT_LIM: readData_r <= otFaultLim_r;
               fsl_pkg::CMD_OT_ACTION:
                  readData_r <= {8'h00, otAction_r};
               fsl_pkg::CMD_OT_WARN_LIM:  readData_r <= otWarnLim_r;
               fsl_pkg::CMD_VIN_OV_LIM:   readData_r <= vinOvLim_r;
               default:                   readData_r <= 16'h0000;
            endcase
         end
      end
   end

   // Write acknowledge and rejection report
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         writeDone_r  <= 1'b0;
         cmdReject_r  <= 1'b0;
         rejectCode_r <= 8'h00;
      end else begin
         writeDone_r <= req.wr && writeOk && !reloadStore;
         // Unmapped reads and bad writes both count as rejected commands
         cmdReject_r <= (req.wr && !writeOk)
                     || (req.rd && !req.wr && !knownCode);
         if ((req.wr && !writeOk) || (req.rd && !req.wr && !knownCode))
            rejectCode_r <= req.code;
      end
   end

   // Sticky rejection flag; a new rejection beats a same-cycle clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         rejectSticky_r <= 1'b0;
      else if ((req.wr && !writeOk) || (req.rd && !req.wr && !knownCode))
         rejectSticky_r <= 1'b1;
      else if (clearFaults)
         rejectSticky_r <= 1'b0;
   end

   // Threshold comparisons against the live measurements
   always_comb begin
      alarm_nxt.otFault    = reaches(meas.temperature, otFaultLim_r);
      alarm_nxt.otWarn     = reaches(meas.temperature, otWarnLim_r);
      alarm_nxt.vinOvFault = reaches(meas.inputVolt, vinOvLim_r);
      alarm_nxt.ocWarn     = reaches(meas.outputCurr, ocWarnLim_r);
   end

   // Alarm levels follow the compare one cycle later
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         alarm_r <= '0;
      else
         alarm_r <= alarm_nxt;
   end

   // Sticky alarm record; a live alarm wins over a clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         alarmSticky_r <= '0;
      else if (clearFaults)
         alarmSticky_r <= alarm_r;
      else
         alarmSticky_r <= alarmSticky_r | alarm_r;
   end

   // Fault action sequencer works from the registered fault level
   fsl_ot_response #(
      .STEP_CYC   (STEP_CYC)
   ) u_ot_resp (
      .clock      (clock),
      .rst        (rst),
      .action     (otAction_r),
      .fault      (alarm_r.otFault),
      .runCmd     (runCmd),
      .clearFault (clearFaults),
      .allowRun   (allowRun)
   );

   // Registered output enable for the power stage
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         outputEnable_r <= 1'b0;
      else
         outputEnable_r <= allowRun;
   end

endmodule : fsl_limit_bank

// ===== verif/fsl_bank_props.sv
// Port-level checks of the threshold register bank
`timescale 1ns/10ps
module fsl_bank_props (
   input wire logic                clock,
   input wire logic                rst,
   input wire fsl_pkg::fsl_req_t   req,
   input wire logic                reloadStore,
   input wire logic                runCmd,
   input wire logic                readValid_r,
   input wire logic                writeDone_r,
   input wire logic                cmdReject_r,
   input wire logic [7:0]          rejectCode_r,
   input wire logic                rejectSticky_r,
   input wire fsl_pkg::fsl_alarm_t alarm_r,
   input wire fsl_pkg::fsl_alarm_t alarmSticky_r,
   input wire logic                outputEnable_r
);
   logic [4:0]  ex;
   logic [10:0] mn;

   // Exponent and mantissa of the offered word
   assign ex = req.data[15:11];
   assign mn = req.data[10:0];

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // One write to one command, not overridden by a reload
   sequence wrOf(logic [7:0] c);
      req.wr && !reloadStore && req.code == c;
   endsequence

   wrAnswer_a: assert property (
      req.wr && !reloadStore |=> writeDone_r != cmdReject_r)
      else $error("write without a single answer");
   reloadWins_a: assert property (
      req.wr && reloadStore |=> !writeDone_r)
      else $error("write accepted over a reload");
   readAnswer_a: assert property (
      req.rd && !req.wr |=> readValid_r != cmdReject_r)
      else $error("read without a single answer");
   rejectSticky_a: assert property (
      cmdReject_r |-> rejectSticky_r)
      else $error("rejection not kept");
   tempRange_a: assert property (
      wrOf(fsl_pkg::CMD_OT_WARN_LIM) ##0 (ex != 5'h00 || mn > 11'h096)
      |=> cmdReject_r && rejectCode_r == fsl_pkg::CMD_OT_WARN_LIM)
      else $error("bad temperature limit taken");
   faultExp_a: assert property (
      wrOf(fsl_pkg::CMD_OT_FAULT_LIM) ##0 ex != 5'h00 |=> cmdReject_r)
      else $error("wrong exponent taken");
   vinRange_a: assert property (
      wrOf(fsl_pkg::CMD_VIN_OV_LIM) ##0 ex == 5'h1F
      && (mn < 11'h002 || mn > 11'h0A0) |=> cmdReject_r)
      else $error("bad input voltage limit taken");
   ocAccept_a: assert property (
      wrOf(fsl_pkg::CMD_OC_WARN_LIM) ##0 ex == 5'h1F && mn <= 11'h0FE
      |=> writeDone_r)
      else $error("good current limit refused");
   alarmKeep_a: assert property (
      alarm_r != 4'h0 |=> (alarmSticky_r & $past(alarm_r)) == $past(alarm_r))
      else $error("raised alarm not kept");
   runOff_a: assert property (
      !runCmd [*2] |=> !outputEnable_r)
      else $error("output on while commanded off");
endmodule : fsl_bank_props

bind fsl_limit_bank fsl_bank_props u_props (
   .clock(clock), .rst(rst), .req(req), .reloadStore(reloadStore),
   .runCmd(runCmd), .readValid_r(readValid_r), .writeDone_r(writeDone_r),
   .cmdReject_r(cmdReject_r), .rejectCode_r(rejectCode_r),
   .rejectSticky_r(rejectSticky_r), .alarm_r(alarm_r),
   .alarmSticky_r(alarmSticky_r), .outputEnable_r(outputEnable_r)
);

// ===== verif/fsl_host_model.sv
// Management bus host issuing one command at a time
`timescale 1ns/10ps
module fsl_host_model (
   input  wire logic        clock,
   input  wire logic        writeDone_r,
   input  wire logic        readValid_r,
   input  wire logic        cmdReject_r,
   input  wire logic [15:0] readData_r,
   output fsl_pkg::fsl_req_t req
);
   // Idle bus until the first command
   initial begin
      req = '0;
   end

   // Strobe held over the taking edge; released fields show junk
   task automatic access(
      input  logic        wr,
      input  logic [7:0]  code,
      input  logic [15:0] data,
      output logic        ok,
      output logic        rej,
      output logic [15:0] rdata
   );
      @(negedge clock);
      req = {wr, !wr, code, data};
      @(posedge clock);
      @(negedge clock);
      ok = wr ? writeDone_r : readValid_r;
      rej = cmdReject_r;
      rdata = readData_r;
      req = {2'b00, ~code, ~data};
   endtask : access
endmodule : fsl_host_model

// ===== verif/tb_top.sv
// Self-checking bench for the threshold register bank
`timescale 1ns/10ps
module tb_top;
   logic                clock;
   logic                rst;
   fsl_pkg::fsl_req_t   req;
   fsl_pkg::fsl_meas_t  meas;
   logic                reloadStore;
   logic                clearFaults;
   logic                runCmd;
   logic [15:0]         readData_r;
   logic                readValid_r;
   logic                writeDone_r;
   logic                cmdReject_r;
   logic [7:0]          rejectCode_r;
   logic                rejectSticky_r;
   fsl_pkg::fsl_alarm_t alarm_r;
   fsl_pkg::fsl_alarm_t alarmSticky_r;
   logic                outputEnable_r;
   logic                done;
   logic                rej;
   logic                acc;
   logic [15:0]         rdat;
   logic [15:0]         d;
   logic [4:0]          e;
   int                  failures;
   int                  samplesChecked;
   int                  cycles;
   int                  i;
   int                  k;
   int                  mdl[5];
   integer              seed;
   integer              r;
   logic [7:0]  codes[5] = '{8'h4A, 8'h4F, 8'h50, 8'h51, 8'h55};
   logic [15:0] dflt[5] = '{16'hF81F, 16'h007D, 16'h00F9, 16'h0069, 16'hF81E};
   logic [10:0] tv[5] = '{11'h068, 11'h069, 11'h07D, 11'h000, 11'h000};
   logic [10:0] vv[5] = '{11'h000, 11'h000, 11'h000, 11'h01D, 11'h01E};
   logic [10:0] cv[5] = '{11'h000, 11'h000, 11'h000, 11'h01E, 11'h01F};
   logic [3:0]  ev[5] = '{4'h0, 4'h4, 4'hC, 4'h0, 4'h3};
   logic [7:0]  acts[4] = '{8'hF9, 8'hC0, 8'h00, 8'hD6};
   logic [2:0]  en[4] = '{3'h3, 3'h1, 3'h7, 3'h3};

   // Short restart step keeps hiccup waits to a few cycles
   fsl_limit_bank #(.STEP_CYC(4)) u_dut (
      .clock(clock), .rst(rst), .req(req), .meas(meas),
      .reloadStore(reloadStore), .clearFaults(clearFaults), .runCmd(runCmd),
      .readData_r(readData_r), .readValid_r(readValid_r),
      .writeDone_r(writeDone_r), .cmdReject_r(cmdReject_r),
      .rejectCode_r(rejectCode_r), .rejectSticky_r(rejectSticky_r),
      .alarm_r(alarm_r), .alarmSticky_r(alarmSticky_r),
      .outputEnable_r(outputEnable_r)
   );
   fsl_host_model u_host (
      .clock(clock), .writeDone_r(writeDone_r), .readValid_r(readValid_r),
      .cmdReject_r(cmdReject_r), .readData_r(readData_r), .req(req)
   );

   // Free-running 200 MHz clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // Acceptance as the ranges and fixed exponents allow
   function automatic bit accepts(input int n, input logic [15:0] w);
      int m;
      m = w[10:0];
      case (n)
         0: return w[15:11] == 5'h1F && m <= 11'h0FE;
         1, 3: return w[15:11] == 5'h00 && m <= 11'h096;
         4: return w[15:11] == 5'h1F && m >= 2 && m <= 11'h0A0;
         default: return 1'b1;
      endcase
   endfunction : accepts

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic test_done();
      $display("checks %0d mismatches %0d", samplesChecked, failures);
      if (failures == 0 && samplesChecked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   task automatic readAll();
      for (int j = 0; j < 5; j++) begin
         u_host.access(1'b0, codes[j], 16'h0000, done, rej, rdat);
         check("valid", {15'h0, done}, 16'h0001);
         check("stored", rdat, mdl[j][15:0]);
      end
   endtask : readAll

   task automatic clearPulse();
      @(negedge clock);
      clearFaults = 1'b1;
      @(negedge clock);
      clearFaults = 1'b0;
   endtask : clearPulse

   // Hang guard, far above the five hundred or so cycles used
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         test_done();
      end
   end

   // Main sequence
   initial begin
      seed = 32'hA5B1;
      rst = 1'b1;
      meas = '0;
      reloadStore = 1'b0;
      clearFaults = 1'b0;
      runCmd = 1'b1;
      repeat (10) @(negedge clock);
      rst = 1'b0;
      for (k = 0; k < 5; k++) mdl[k] = dflt[k];
      readAll();
      $display("test reset values done");
      // Random writes, many outside range or resolution
      for (k = 0; k < 80; k++) begin
         r = $random(seed);
         i = r[10:8] % 5;
         e = (i == 1 || i == 3) ? 5'h00 : 5'h1F;
         d = {r[3] ? e : r[8:4], r[31] ? r[26:16] : {3'h0, r[23:16]}};
         acc = accepts(i, d);
         u_host.access(1'b1, codes[i], d, done, rej, rdat);
         check("answer", {14'h0, done, rej}, {14'h0, acc, !acc});
         if (!acc) check("code", {8'h00, rejectCode_r}, {8'h00, codes[i]});
         else mdl[i] = (i == 2) ? d & 16'h00FF : d;
         u_host.access(1'b0, codes[i], 16'h0000, done, rej, rdat);
         check("readback", rdat, mdl[i][15:0]);
      end
      u_host.access(1'b0, 8'h4B, 16'h0000, done, rej, rdat);
      check("unmapped", {14'h0, done, rej}, 16'h0001);
      $display("test writes done");
      // Reload brings every default back
      @(negedge clock);
      reloadStore = 1'b1;
      @(negedge clock);
      reloadStore = 1'b0;
      for (k = 0; k < 5; k++) mdl[k] = dflt[k];
      readAll();
      // Alarms just below and at each threshold; temperature fault only at its threshold
      for (k = 0; k < 5; k++) begin
         meas = {tv[k], vv[k], cv[k]};
         repeat (2) @(negedge clock);
         check("alarm", {12'h000, alarm_r}, {12'h000, ev[k]});
      end
      meas = '0;
      // Every alarm has been raised and rejections were seen
      check("sticky alarms", {12'h000, alarmSticky_r}, 16'h000F);
      check("sticky reject", {15'h0, rejectSticky_r}, 16'h0001);
      clearPulse();
      check("alarms cleared", {12'h000, alarmSticky_r}, 16'h0000);
      check("reject cleared", {15'h0, rejectSticky_r}, 16'h0000);
      $display("test alarms done");
      // Fault actions: in fault, after it, after clearing
      for (k = 0; k < 4; k++) begin
         u_host.access(1'b1, 8'h50, {8'h00, acts[k]}, done, rej, rdat);
         meas.temperature = 11'h082;
         repeat (8) @(negedge clock);
         check("in fault", {15'h0, outputEnable_r}, {15'h0, en[k][2]});
         meas.temperature = 11'h000;
         repeat (16) @(negedge clock);
         check("fault gone", {15'h0, outputEnable_r}, {15'h0, en[k][1]});
         clearPulse();
         repeat (4) @(negedge clock);
         check("cleared", {15'h0, outputEnable_r}, {15'h0, en[k][0]});
      end
      runCmd = 1'b0;
      repeat (4) @(negedge clock);
      check("run off", {15'h0, outputEnable_r}, 16'h0000);
      $display("test responses done");
      test_done();
   end
endmodule : tb_top
